// [verification/pct_far.sv]
// Remote terminal channel model: one tone per remote current polarity
`timescale 1ns/10ps
module pct_far (
  input  wire logic        i_on,
  input  wire logic        i_rem_pos,
  output pct_pkg::pct_rx_t o_rx
);
  // Remote keyed by the same rule; tones are exclusive
  assign o_rx = '{i_on && i_rem_pos, i_on && !i_rem_pos};
endmodule

// [verification/pct_trip_asserts.sv]
// Port checks for the phase comparison trip logic
`timescale 1ns/10ps
module pct_trip_asserts (
  input wire logic              i_core_clk,
  input wire logic              i_resetn,
  input wire logic              i_sync_clr,
  input wire pct_pkg::pct_cfg_t i_cfg,
  input wire logic              i_pos_half,
  input wire logic              i_neg_half,
  input wire logic              i_high_set_fault_detector,
  input wire logic              i_low_set_fault_detector,
  input wire pct_pkg::pct_rx_t  i_rx_a,
  input wire logic              o_trip,
  input wire logic              o_tx_key,
  input wire logic              o_coincidence_gate
);
  wire lh  = i_cfg.neg_half ? i_neg_half : i_pos_half;
  wire fsk = i_cfg.channel == pct_pkg::PCT_CH_FSK;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  a_gate_detector: assert property (!(i_high_set_fault_detector && lh) |-> !o_coincidence_gate)
    else $error("gate open");
  a_trip_mark: assert property (fsk && !i_cfg.blocking && !i_cfg.neg_half && !i_rx_a.pos_tone |->
    !o_coincidence_gate) else $error("no mark");
  a_block_space: assert property (fsk && i_cfg.blocking && !i_cfg.neg_half && i_rx_a.neg_tone |->
    !o_coincidence_gate) else $error("space seen");
  a_neg_space: assert property (fsk && !i_cfg.blocking && i_cfg.neg_half && !i_rx_a.neg_tone |->
    !o_coincidence_gate) else $error("no space");
  a_trip_cause: assert property ($rose(o_trip) |-> $past(o_coincidence_gate))
    else $error("trip uncaused");
  a_trip_hold: assert property (disable iff (!i_resetn || i_sync_clr) $rose(o_trip) |=> o_trip[*8])
    else $error("trip short");
  a_key_on: assert property (i_low_set_fault_detector && !lh && !i_sync_clr |=> o_tx_key)
    else $error("key off");
  a_key_off: assert property (lh |=> !o_tx_key)
    else $error("key on");
endmodule
bind pct_trip pct_trip_asserts u_chk (.*);

// [verification/tb.sv]
// Directed testbench for the phase comparison trip logic
`timescale 1ns/10ps
module tb;
  logic              clk = 0, rstn = 0, clr = 0, ph = 0, nh = 0, hs = 0, ls = 0;
  logic              ona = 0, pa = 0, onb = 0, pb = 0, trip, key, conf;
  pct_pkg::pct_cfg_t cfg = '0;
  pct_pkg::pct_rx_t  rxa, rxb;
  int                mismatches = 0, checked = 0;
  pct_trip #(.EXTEND_CYC(20)) u_dut (.i_core_clk(clk), .i_resetn(rstn), .i_sync_clr(clr), .i_cfg(cfg),
    .i_pickup_cyc(20'h00004), .i_pos_half(ph), .i_neg_half(nh), .i_high_set_fault_detector(hs),
    .i_low_set_fault_detector(ls), .i_rx_a(rxa), .i_rx_b(rxb), .o_trip(trip), .o_tx_key(key),
    .o_coincidence_gate(), .o_tone_conflict(conf));
  pct_far u_fa (.i_on(ona), .i_rem_pos(pa), .o_rx(rxa));
  pct_far u_fb (.i_on(onb), .i_rem_pos(pb), .o_rx(rxb));
  initial forever #12.5 clk = ~clk;
  task chk(input logic s, input logic e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_sim;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Mask bits: blocking, on-off, three terminals, negative half
  task t(input logic [3:0] m, input logic h, a, p, b, q, input int n, input logic e);
    @(posedge clk);
    clr <= 1;
    cfg <= '{m[3], m[2] ? pct_pkg::PCT_CH_ONOFF : pct_pkg::PCT_CH_FSK, m[1], m[0]};
    {hs, ls, ona, pa, onb, pb} <= {h, h, a, p, b, q};
    @(posedge clk);
    clr <= 0;
    ph <= !m[0];
    nh <= m[0];
    repeat (n) @(posedge clk);
    #1 chk(trip, e);
    chk(key, 1'b0);
    chk(conf, 1'b0);
    @(posedge clk);
    ph <= 0;
    nh <= 0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    t(4'b0000, 1, 1, 1, 0, 0, 4, 1);
    repeat (18) @(posedge clk);
    #1 chk(trip, 1'b1);
    chk(key, 1'b1);
    repeat (3) @(posedge clk);
    #1 chk(trip, 1'b0);
    t(4'b0000, 1, 1, 1, 0, 0, 3, 0);
    t(4'b0000, 1, 1, 0, 0, 0, 4, 0);
    t(4'b0000, 0, 1, 1, 0, 0, 4, 0);
    t(4'b1000, 1, 0, 0, 0, 0, 4, 1);
    t(4'b1000, 1, 1, 0, 0, 0, 4, 0);
    t(4'b0100, 1, 1, 1, 0, 0, 4, 1);
    t(4'b0100, 1, 0, 0, 0, 0, 4, 0);
    t(4'b1100, 1, 0, 0, 0, 0, 4, 1);
    t(4'b1100, 1, 1, 1, 0, 0, 4, 0);
    t(4'b0010, 1, 1, 1, 1, 1, 4, 1);
    t(4'b0010, 1, 1, 1, 0, 0, 4, 0);
    t(4'b0001, 1, 1, 0, 0, 0, 4, 1);
    t(4'b0001, 1, 1, 1, 0, 0, 4, 0);
    end_sim;
  end
  initial begin
    #75000;
    mismatches++;
    end_sim;
  end
endmodule

// [verilog/pct_defs.svh]
// Timing constants and setting defaults for the phase comparison trip logic
`ifndef PCT_DEFS_SVH
`define PCT_DEFS_SVH

`define PCT_CLK_HZ          40000000
`define PCT_CNT_W           20
`define PCT_PICKUP_US       3000
`define PCT_PICKUP_CYC      (`PCT_PICKUP_US * (`PCT_CLK_HZ / 1000000))
`define PCT_EXTEND_US       18000
`define PCT_EXTEND_CYC      (`PCT_EXTEND_US * (`PCT_CLK_HZ / 1000000))
`define PCT_HALF60_US       8333
`define PCT_HALF50_US       10000

`endif

// [verilog/pct_pkg.sv]
// Types for the phase comparison trip logic
package pct_pkg;

  typedef enum logic [1:0] {
    PCT_CH_FSK    = 2'b00,
    PCT_CH_ONOFF  = 2'b01
  } pct_channel_t;

  typedef enum logic [1:0] {
    PCT_ST_IDLE   = 2'b00,
    PCT_ST_PICK   = 2'b01,
    PCT_ST_TRIP   = 2'b11
  } pct_state_t;

  // One remote receiver's outputs
  typedef struct packed {
    logic pos_tone;
    logic neg_tone;
  } pct_rx_t;

  // Scheme configuration
  typedef struct packed {
    logic         blocking;
    pct_channel_t channel;
    logic         three_term;
    logic         neg_half;
  } pct_cfg_t;

endpackage

// [verilog/pct_trip.sv]
// Phase comparison coincidence integrator, trip extension and transmitter keying
// Operation
// - FSK trip: positive current with positive tone
// - Hold trip asserted 18 ms after pickup
// - FSK block: positive current without negative tone
// - Pickup time is a setting, nominally 3-4 ms
// - Pickup time acts as stability angle
// - On-off receiver output: present or absent only
// - Three terminals use both remote receivers
// - Negative half mode uses negative current, tone
// - Compare only while high-set detector asserted
// - Block trips after 3 ms absence, detector on
// - Key on low-set, off in compared half (positive, or negative in negative half mode)
// - All terminals key by identical rule
`timescale 1ns/10ps
`include "pct_defs.svh"

module pct_trip #(
  parameter int unsigned CNT_W      = `PCT_CNT_W,
  parameter int unsigned EXTEND_CYC = `PCT_EXTEND_CYC
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_resetn,
  input  wire logic                   i_sync_clr,
  input  wire pct_pkg::pct_cfg_t      i_cfg,
  input  wire logic [CNT_W-1:0]       i_pickup_cyc,
  input  wire logic                   i_pos_half,
  input  wire logic                   i_neg_half,
  input  wire logic                   i_high_set_fault_detector,
  input  wire logic                   i_low_set_fault_detector,
  input  wire pct_pkg::pct_rx_t       i_rx_a,
  input  wire pct_pkg::pct_rx_t       i_rx_b,
  output logic                        o_trip,
  output logic                        o_tx_key,
  output logic                        o_coincidence_gate,
  output logic                        o_tone_conflict
);

  // Hold counts down from EXTEND_CYC-1 so trip stands exactly EXTEND_CYC cycles
  localparam logic [CNT_W-1:0] EXT_LOAD = CNT_W'(EXTEND_CYC - 1);

  // Comparison state: integrator, hold timer and trip flag
  pct_pkg::pct_state_t state_q, state_d;
  logic [CNT_W-1:0]    integ_q, integ_d;
  logic [CNT_W-1:0]    ext_q, ext_d;
  logic                trip_q, trip_d;

  // Keying and channel supervision
  logic                key_q, key_d;
  logic                conflict_q, conflict_d;

  logic              local_half;
  pct_pkg::pct_rx_t  rx_end [2];
  logic [1:0]        agree;
  logic [1:0]        both_tones;
  logic              coinc;
  logic              pickup_hit;

  // Index 1 is the second remote end, present only on a three-terminal line
  assign rx_end[0] = i_rx_a;
  assign rx_end[1] = i_rx_b;

  // The compared half of the local squaring stage
  assign local_half = i_cfg.neg_half ? i_neg_half : i_pos_half;

  // Receiver view per remote end
  for (genvar g = 0; g < 2; g++) begin : g_rem
    logic mark;
    logic space;

    always_comb begin
      if (i_cfg.channel == pct_pkg::PCT_CH_ONOFF) begin
        // An on-off receiver is only present or absent, so it stands for both tones
        mark  = rx_end[g].pos_tone;
        space = rx_end[g].pos_tone;
      end else if (i_cfg.neg_half) begin
        mark  = rx_end[g].neg_tone;
        space = rx_end[g].pos_tone;
      end else begin
        mark  = rx_end[g].pos_tone;
        space = rx_end[g].neg_tone;
      end
    end

    // Tripping needs the agreeing tone; blocking needs the opposing tone absent
    assign agree[g]      = i_cfg.blocking ? ~space : mark;
    assign both_tones[g] = rx_end[g].pos_tone & rx_end[g].neg_tone;
  end

  // Both remote ends must agree on a three-terminal line; otherwise the second is ignored
  assign coinc = i_high_set_fault_detector & local_half & agree[0]
                 & (agree[1] | ~i_cfg.three_term);

  // Pickup is reached once the gate has held for the set count
  assign pickup_hit = (integ_q + CNT_W'(1)) >= i_pickup_cyc;

  always_comb begin
    state_d    = state_q;
    integ_d    = integ_q;
    ext_d      = ext_q;
    trip_d     = trip_q;
    case (state_q)
      pct_pkg::PCT_ST_IDLE: begin
        integ_d = '0;
        if (coinc) begin
          integ_d = CNT_W'(1);
          state_d = pct_pkg::PCT_ST_PICK;
          if (i_pickup_cyc <= CNT_W'(1)) begin
            state_d = pct_pkg::PCT_ST_TRIP;
            trip_d  = 1'b1;
            ext_d   = EXT_LOAD;
          end
        end
      end
      pct_pkg::PCT_ST_PICK: begin
        if (!coinc) begin
          integ_d = '0;
          state_d = pct_pkg::PCT_ST_IDLE;
        end else if (pickup_hit) begin
          integ_d = '0;
          trip_d  = 1'b1;
          ext_d   = EXT_LOAD;
          state_d = pct_pkg::PCT_ST_TRIP;
        end else begin
          integ_d = integ_q + CNT_W'(1);
        end
      end
      pct_pkg::PCT_ST_TRIP: begin
        // A fresh coincidence during the hold restarts pickup timing
        if (coinc) begin
          if (pickup_hit) begin
            integ_d = '0;
            ext_d   = EXT_LOAD;
          end else begin
            integ_d = integ_q + CNT_W'(1);
            ext_d   = (ext_q == '0) ? '0 : ext_q - CNT_W'(1);
          end
        end else begin
          integ_d = '0;
          ext_d   = (ext_q == '0) ? '0 : ext_q - CNT_W'(1);
        end
        // Hold expired: a running coincidence keeps its partial count rather than restarting
        if (ext_q == '0 && !(coinc && pickup_hit)) begin
          trip_d  = 1'b0;
          state_d = coinc ? pct_pkg::PCT_ST_PICK : pct_pkg::PCT_ST_IDLE;
        end
      end
      default: begin
        state_d = pct_pkg::PCT_ST_IDLE;
        integ_d = '0;
        ext_d   = '0;
        trip_d  = 1'b0;
      end
    endcase
    if (i_sync_clr) begin
      state_d = pct_pkg::PCT_ST_IDLE;
      integ_d = '0;
      ext_d   = '0;
      trip_d  = 1'b0;
    end
  end

  // Keying is the same at every terminal so blocking tones mean the same everywhere
  always_comb begin
    key_d = i_low_set_fault_detector & ~local_half;
    if (i_sync_clr) begin
      key_d = 1'b0;
    end
  end

  // Both tones at once is a channel fault; it is only flagged, never used to trip
  always_comb begin
    conflict_d = both_tones[0] | (i_cfg.three_term & both_tones[1]);
    if (i_sync_clr) begin
      conflict_d = 1'b0;
    end
  end

  // Integrator, hold timer and trip flag
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= pct_pkg::PCT_ST_IDLE;
      integ_q <= '0;
      ext_q   <= '0;
      trip_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      integ_q <= integ_d;
      ext_q   <= ext_d;
      trip_q  <= trip_d;
    end
  end

  // Key is registered so the transmitter never sees a combinational glitch
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      key_q <= 1'b0;
    end else begin
      key_q <= key_d;
    end
  end

  // Conflict flag
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      conflict_q <= 1'b0;
    end else begin
      conflict_q <= conflict_d;
    end
  end

  assign o_trip             = trip_q;
  assign o_tx_key           = key_q;
  assign o_coincidence_gate = coinc;
  assign o_tone_conflict    = conflict_q;

endmodule
